/* File: design/ecr_top.sv */
// Operation
// - Per-axis select: analog sin/cos or quadrature
// - Per-axis referencing mode 0..3, reset 0
// - Mode 1: limit switch, then mark, load
// - Mode 1, limit disabled: mark only
// - Mode 1 loads configurable origin offset
// - Mode 2: match taught analog signal phase
// - Mode 3: match taught motor step position
// - Search velocity; mark-only uses capped velocity
// - Per-axis fault input enable, reset 0
// - Enabled asserted fault sets encoder error
// - Fault input low means fault
// - Write all axes or one axis alone
// - Encoder error switches closed loop off
// - Fault status reads inverse of pin
module ecr_top (
   input  wire logic                  clock,
   input  wire logic                  nrst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire ecr_pkg::ecr_pins_type pins,
   output ecr_pkg::ecr_move_type      motion,
   output logic      [1:0]            cal_axis,
   output logic                       cal_busy,
   output logic [ecr_pkg::AXES-1:0]   closed_loop_en,
   output logic [ecr_pkg::AXES-1:0]   analog_sel,
   output logic                       irq
);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   ecr_pkg::ecr_state_type q;       // Registered state
   ecr_pkg::ecr_state_type d;       // Next state

   // Bus phase decode
   logic        setup;              // Setup phase of a transfer
   logic        wr;                 // Write taking effect now
   logic        align;              // Word aligned address
   logic [1:0]  idx;                // Word index within a group
   logic [31:0] base;               // Velocity before the ceiling
   ecr_pkg::ecr_ref_type mode;      // Mode of the axis in work
   logic [ecr_pkg::CW-1:0] acfg;    // Config of the axis in work
   logic        ok;                 // Address is mapped

   assign setup = psel & ~penable;
   assign wr    = psel & penable & pwrite;
   assign align = (paddr[1:0] == 2'h0);
   assign idx   = paddr[3:2];
   assign acfg  = q.cfg[q.axis];
   assign mode  = ecr_pkg::ecr_ref_type'(acfg[ecr_pkg::F_MODE +: 2]);

   // Mark-only calibration takes normal or extended speed, capped
   assign base = q.ext ? q.vel[ecr_pkg::V_CAL]
                       : q.vel[ecr_pkg::V_NORM];

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign prdata   = q.rdata;
   assign pslverr  = q.slverr & psel & penable;
   assign pready   = 1'b1;         // Zero wait states
   assign motion   = q.mv;
   assign cal_axis = q.axis;
   assign cal_busy = (q.st != ecr_pkg::S_IDLE);
   // Error drops the loop at once, not a cycle later
   assign closed_loop_en = ~q.err;
   assign irq      = |(q.ist & q.imsk);

   // Quadrature bit inverted: 1 means sin/cos path in use
   always_comb begin
      for (int a = 0; a < ecr_pkg::AXES; a++) begin
         analog_sel[a] = ~q.cfg[a][ecr_pkg::F_SEL];
      end
   end

   // -------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------
   always_comb begin
      d = q;
      ok = align;
      // Two flops on every pin; stage one feeds stage two only
      d.s1 = pins;
      d.s2 = q.s1;
      d.mv.load = 1'b0;

      // Read data is fetched in setup, held for the access phase
      if (setup) begin
         d.rdata = 32'h0000_0000;
         case (paddr[7:4])
            ecr_pkg::N_ALL: begin
               ok = align & (idx == 2'h0);
               for (int a = 0; a < ecr_pkg::AXES; a++) begin
                  d.rdata[a*ecr_pkg::LANE +: ecr_pkg::CW] = q.cfg[a];
               end
            end
            ecr_pkg::N_AXIS: begin
               d.rdata[ecr_pkg::CW-1:0] = q.cfg[idx];
            end
            ecr_pkg::N_OFS: begin
               d.rdata = q.ofs[idx];
            end
            ecr_pkg::N_VEL: begin
               d.rdata = q.vel[idx];
            end
            ecr_pkg::N_CTL: begin
               case (idx)
                  ecr_pkg::I_CTRL: begin
                     d.rdata[ecr_pkg::C_AX +: 2] = q.axis;
                     d.rdata[ecr_pkg::C_EXT]     = q.ext;
                     d.rdata[ecr_pkg::C_BSY]     = cal_busy;
                  end
                  ecr_pkg::I_STAT: begin
                     // Fault state is the inverted pin level
                     d.rdata[3:0]  = ~q.s2.fault_n;
                     d.rdata[7:4]  = q.err;
                     d.rdata[11:8] = ~q.err;
                  end
                  ecr_pkg::I_IST: begin
                     d.rdata[ecr_pkg::IW-1:0] = q.ist;
                  end
                  default: begin
                     d.rdata[ecr_pkg::IW-1:0] = q.imsk;
                  end
               endcase
            end
            default: begin
               ok = 1'b0;
            end
         endcase
         d.slverr = ~ok;
      end

      // Writes land at the access edge; reads change nothing
      if (wr && !q.slverr) begin
         case (paddr[7:4])
            ecr_pkg::N_ALL: begin
               for (int a = 0; a < ecr_pkg::AXES; a++) begin
                  d.cfg[a] = pwdata[a*ecr_pkg::LANE +: ecr_pkg::CW];
               end
            end
            ecr_pkg::N_AXIS: begin
               // Other axes keep their values
               d.cfg[idx] = pwdata[ecr_pkg::CW-1:0];
            end
            ecr_pkg::N_OFS: begin
               d.ofs[idx] = pwdata;
            end
            ecr_pkg::N_VEL: begin
               d.vel[idx] = pwdata;
            end
            ecr_pkg::N_CTL: begin
               case (idx)
                  ecr_pkg::I_CTRL: begin
                     // Settings are frozen while a run is going
                     if (q.st == ecr_pkg::S_IDLE) begin
                        d.ext  = pwdata[ecr_pkg::C_EXT];
                        d.axis = pwdata[ecr_pkg::C_AX +: 2];
                        if (pwdata[ecr_pkg::C_GO]) begin
                           d.st = ecr_pkg::S_LIMIT;
                           // Mark-only run when limit unused
                           if (d.cfg[d.axis][ecr_pkg::F_MODE +: 2] ==
                               ecr_pkg::REF_MARK &&
                               !d.cfg[d.axis][ecr_pkg::F_LIM]) begin
                              d.st = ecr_pkg::S_MARK;
                           end
                        end
                     end
                  end
                  ecr_pkg::I_STAT: begin
                     d.err = q.err & ~pwdata[7:4];
                  end
                  ecr_pkg::I_IST: begin
                     d.ist = q.ist & ~pwdata[ecr_pkg::IW-1:0];
                  end
                  default: begin
                     d.imsk = pwdata[ecr_pkg::IW-1:0];
                  end
               endcase
            end
            default: begin
               d.slverr = 1'b1;
            end
         endcase
      end

      // Fault pin: low asserts, only where enabled; set wins
      for (int a = 0; a < ecr_pkg::AXES; a++) begin
         if (q.cfg[a][ecr_pkg::F_FLT] &&
             !q.s2.fault_n[a]) begin
            d.err[a] = 1'b1;
            if (!q.err[a]) begin
               d.ist[ecr_pkg::I_ERR + a] = 1'b1;
            end
         end
      end

      // Calibration sequencer
      case (q.st)
         ecr_pkg::S_IDLE: begin
            d.mv.move = 1'b0;
         end
         ecr_pkg::S_LIMIT: begin
            d.mv.move = 1'b1;
            d.mv.dir  = 1'b0;
            d.mv.vel  = base;
            if (q.s2.lim[q.axis]) begin
               d.mv.move = 1'b0;
               case (mode)
                  ecr_pkg::REF_MARK: begin
                     d.st = ecr_pkg::S_MARK;
                  end
                  ecr_pkg::REF_PHASE: begin
                     // Phase match needs the sin/cos path
                     if (!acfg[ecr_pkg::F_SEL]) begin
                        d.st = ecr_pkg::S_MATCH;
                     end else begin
                        d.mv.load = 1'b1;
                        d.mv.pos  = ecr_pkg::OFS_RST;
                        d.st      = ecr_pkg::S_DONE;
                     end
                  end
                  ecr_pkg::REF_STEP: begin
                     d.st = ecr_pkg::S_MATCH;
                  end
                  default: begin
                     d.mv.load = 1'b1;
                     d.mv.pos  = ecr_pkg::OFS_RST;
                     d.st      = ecr_pkg::S_DONE;
                  end
               endcase
            end
         end
         ecr_pkg::S_MARK: begin
            d.mv.move = 1'b1;
            d.mv.dir  = 1'b1;
            if (acfg[ecr_pkg::F_LIM]) begin
               d.mv.vel = q.vel[ecr_pkg::V_SRCH];
            end else if (base > q.vel[ecr_pkg::V_CEIL]) begin
               d.mv.vel = q.vel[ecr_pkg::V_CEIL];
            end else begin
               d.mv.vel = base;
            end
            if (q.s2.mark[q.axis]) begin
               d.mv.move = 1'b0;
               d.mv.load = 1'b1;
               d.mv.pos  = q.ofs[q.axis];
               d.st      = ecr_pkg::S_DONE;
            end
         end
         ecr_pkg::S_MATCH: begin
            d.mv.move = 1'b1;
            d.mv.dir  = 1'b1;
            d.mv.vel  = q.vel[ecr_pkg::V_SRCH];
            // Match source follows the mode of the axis
            if ((mode == ecr_pkg::REF_PHASE &&
                 q.s2.phase[q.axis]) ||
                (mode == ecr_pkg::REF_STEP &&
                 q.s2.step[q.axis])) begin
               d.mv.move = 1'b0;
               d.mv.load = 1'b1;
               d.mv.pos  = ecr_pkg::OFS_RST;
               d.st      = ecr_pkg::S_DONE;
            end
         end
         ecr_pkg::S_DONE: begin
            d.mv.move = 1'b0;
            d.ist[ecr_pkg::I_DONE] = 1'b1;
            d.st = ecr_pkg::S_IDLE;
         end
         default: begin
            d.st = ecr_pkg::S_IDLE;
         end
      endcase

      // Invalid encoder aborts the run without loading
      if (q.err[q.axis] && q.st != ecr_pkg::S_IDLE &&
          q.st != ecr_pkg::S_DONE) begin
         d.mv.move = 1'b0;
         d.mv.load = 1'b0;
         d.st      = ecr_pkg::S_DONE;
      end
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         q        <= '0;
         q.s1     <= '1;               // Pins idle: fault_n high
         q.s2     <= '1;
         q.s1.lim <= '0;
         q.s2.lim <= '0;
         q.s1.mark  <= '0;
         q.s2.mark  <= '0;
         q.s1.phase <= '0;
         q.s2.phase <= '0;
         q.s1.step  <= '0;
         q.s2.step  <= '0;
         q.cfg    <= {ecr_pkg::AXES{ecr_pkg::CFG_RST}};
         q.st     <= ecr_pkg::S_IDLE;
      end else begin
         q <= d;
      end
   end

endmodule : ecr_top

/* File: inc/ecr_pkg.sv */
package ecr_pkg;

   // -------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------
   localparam int AXES = 4;         // Axes served by the block
   localparam int CW   = 5;         // Config bits per axis

   // -------------------------------------------------------------
   // Register map (byte addresses, high nibble selects group)
   // -------------------------------------------------------------
   localparam logic [3:0] N_ALL  = 4'h0; // All axes config, 0x00
   localparam logic [3:0] N_AXIS = 4'h1; // One axis config, 0x10+4a
   localparam logic [3:0] N_OFS  = 4'h2; // Origin offset, 0x20+4a
   localparam logic [3:0] N_VEL  = 4'h3; // Velocities, 0x30..0x3C
   localparam logic [3:0] N_CTL  = 4'h4; // Control group, 0x40..
   localparam logic [1:0] I_CTRL = 2'h0; // 0x40 calibration control
   localparam logic [1:0] I_STAT = 2'h1; // 0x44 fault and error state
   localparam logic [1:0] I_IST  = 2'h2; // 0x48 irq status, w1c
   localparam logic [1:0] I_IMSK = 2'h3; // 0x4C irq mask

   // Velocity slots within the N_VEL group
   localparam int V_SRCH = 0;       // Reference search velocity
   localparam int V_NORM = 1;       // Normal velocity
   localparam int V_CAL  = 2;       // Extended calibration velocity
   localparam int V_CEIL = 3;       // Velocity ceiling

   // -------------------------------------------------------------
   // Per-axis config field positions and reset value
   // -------------------------------------------------------------
   localparam int F_SEL  = 0;       // 0 analog sin/cos, 1 quadrature
   localparam int F_MODE = 1;       // Two-bit referencing mode
   localparam int F_FLT  = 3;       // Fault input enable
   localparam int F_LIM  = 4;       // Limit switch in use
   localparam int LANE   = 8;       // Byte lane per axis in ALL reg
   localparam logic [CW-1:0] CFG_RST = 5'h10;
   localparam logic [31:0]   VEL_RST = 32'h0000_0000;
   localparam logic [31:0]   OFS_RST = 32'h0000_0000;

   // Control register bits
   localparam int C_GO  = 0;        // Start calibration (write)
   localparam int C_AX  = 1;        // Axis, two bits
   localparam int C_EXT = 3;        // Extended calibration mode
   localparam int C_BSY = 4;        // Busy (read)

   // Interrupt status bits
   localparam int IW     = 5;
   localparam int I_DONE = 0;       // Calibration finished
   localparam int I_ERR  = 1;       // Encoder error, one per axis

   typedef enum logic [1:0] {
      REF_NONE  = 2'h0,
      REF_MARK  = 2'h1,
      REF_PHASE = 2'h2,
      REF_STEP  = 2'h3
   } ecr_ref_type;

   typedef enum logic [4:0] {
      S_IDLE  = 5'h01,
      S_LIMIT = 5'h02,
      S_MARK  = 5'h04,
      S_MATCH = 5'h08,
      S_DONE  = 5'h10
   } ecr_fsm_type;

   // Encoder and switch pins, one bit per axis
   typedef struct packed {
      logic [AXES-1:0] lim;         // Lower limit switch reached
      logic [AXES-1:0] mark;        // Encoder reference mark
      logic [AXES-1:0] phase;       // Taught signal phase matched
      logic [AXES-1:0] step;        // Taught step position matched
      logic [AXES-1:0] fault_n;     // Encoder fault input, low = fault
   } ecr_pins_type;

   // Motion request towards the axis drive
   typedef struct packed {
      logic        move;            // Axis is to move
      logic        dir;             // 0 towards lower limit
      logic [31:0] vel;             // Commanded velocity
      logic        load;            // Load position, one cycle
      logic [31:0] pos;             // Value to load
   } ecr_move_type;

   typedef struct packed {
      ecr_pins_type                 s1;
      ecr_pins_type                 s2;
      logic [AXES-1:0][CW-1:0]      cfg;
      logic [AXES-1:0][31:0]        ofs;
      logic [3:0][31:0]             vel;
      logic                         ext;
      logic [AXES-1:0]              err;
      logic [IW-1:0]                ist;
      logic [IW-1:0]                imsk;
      ecr_fsm_type                  st;
      logic [1:0]                   axis;
      ecr_move_type                 mv;
      logic [31:0]                  rdata;
      logic                         slverr;
   } ecr_state_type;

endpackage : ecr_pkg

/* File: verification/ecr_monitor.sv */
module ecr_monitor (
   input wire logic                      clock,
   input wire logic                      nrst,
   input wire logic                      psel,
   input wire logic                      penable,
   input wire logic                      pwrite,
   input wire logic [7:0]                paddr,
   input wire logic [31:0]               pwdata,
   input wire logic [31:0]               prdata,
   input wire logic                      pready,
   input wire logic                      pslverr,
   input wire ecr_pkg::ecr_pins_type     pins,
   input wire ecr_pkg::ecr_move_type     motion,
   input wire logic [1:0]                cal_axis,
   input wire logic                      cal_busy,
   input wire logic [ecr_pkg::AXES-1:0]  closed_loop_en,
   input wire logic [ecr_pkg::AXES-1:0]  analog_sel,
   input wire logic                      irq
);
   timeunit 1ns;
   timeprecision 1ps;

   // -------------------------------------------------------------
   // Common clocking and steps
   // -------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   // Start seen, then motion within two cycles
   sequence start_s; $rose(cal_busy); endsequence
   sequence seek_s; ##[0:2] motion.move; endsequence
   // Load is one cycle, then the run winds up
   sequence wind_s; ##1 !motion.load ##[0:1] !cal_busy; endsequence
   // Access writing the single-axis config of axis 0
   sequence ax0_wr_s; psel && penable && pwrite && paddr == 8'h10; endsequence

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   pready_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   slverr_a: assert property (pslverr |-> psel && penable)
      else $error("error flag outside access phase");
   sel_write_a: assert property (
      ax0_wr_s |=> analog_sel[0] == !$past(pwdata[0]))
      else $error("encoder select not taken from write");
   sel_keep_a: assert property (
      ax0_wr_s |=> $stable(analog_sel[3:1]))
      else $error("other axes changed by single-axis write");
   seek_go_a: assert property (start_s |-> seek_s)
      else $error("calibration started without motion");
   load_end_a: assert property (
      motion.load |-> cal_busy ##0 wind_s)
      else $error("load not a single cycle ending the run");
   axis_hold_a: assert property (
      cal_busy && $past(cal_busy) |-> $stable(cal_axis))
      else $error("axis changed during calibration");
   // Error only after a low fault level passed the synchroniser
   for (genvar a = 0; a < ecr_pkg::AXES; a++) begin : g_flt
      fault_err_a: assert property (
         $fell(closed_loop_en[a]) |-> !($past(pins.fault_n[a], 2)
         && $past(pins.fault_n[a], 3) && $past(pins.fault_n[a], 4)))
         else $error("closed loop off without fault input");
   end
endmodule : ecr_monitor

bind ecr_top ecr_monitor i_ecr_monitor (
   .clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .pins, .motion, .cal_axis, .cal_busy,
   .closed_loop_en, .analog_sel, .irq
);

/* File: verification/ecr_enc_model.sv */
module ecr_enc_model (
   input  wire logic                  clock,
   input  wire logic                  slow,
   input  wire logic [3:0]            flt_n,
   input  wire ecr_pkg::ecr_move_type motion,
   input  wire logic [1:0]            cal_axis,
   output ecr_pkg::ecr_pins_type      pins
);
   timeunit 1ns;
   timeprecision 1ps;

   int unsigned           run_q; // Cycles moved in one direction
   logic                  dir_q; // Direction seen last cycle
   ecr_pkg::ecr_pins_type nx;    // Pin levels for the next cycle

   // -------------------------------------------------------------
   // Switch and encoder events follow the commanded travel
   // -------------------------------------------------------------
   always @(posedge clock) begin
      // Built whole first so the pins see one assignment a cycle
      nx         = '0;
      nx.fault_n = flt_n;
      // Events wait for travel; slow stands for a long approach
      if (motion.move && run_q >= (slow ? 40 : 3)) begin
         if (!motion.dir) begin
            nx.lim[cal_axis] = 1'b1;
         end else begin
            nx.mark[cal_axis]  = 1'b1;
            nx.phase[cal_axis] = 1'b1;
            nx.step[cal_axis]  = 1'b1;
         end
      end
      run_q <= (motion.move && motion.dir == dir_q) ? run_q + 1 : 0;
      dir_q <= motion.dir;
      pins  <= nx;
   end
endmodule : ecr_enc_model

/* File: verification/ecr_top_tb.sv */
module ecr_top_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // -------------------------------------------------------------
   // Signals and bench state
   // -------------------------------------------------------------
   logic                  clock, nrst, psel, penable, pwrite;
   logic [7:0]            paddr;
   logic [31:0]           pwdata, prdata;
   logic                  pready, pslverr, cal_busy, irq, slow;
   ecr_pkg::ecr_pins_type pins;
   ecr_pkg::ecr_move_type motion;
   logic [1:0]            cal_axis, mv_q;
   logic [3:0]            closed_loop_en, analog_sel, flt_n;
   logic [31:0]           vs, vn, vc, vx, w;
   int                    fail_count = 0;
   int                    n_tests = 0;
   int                    seed = 32'h088C45BF;
   logic [32:0]           rd_q[$];   // Bit 32 marks an expected refusal
   logic [31:0]           ld_q[$], vel_q[$];

   ecr_top i_ecr_top (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pins, .motion, .cal_axis,
      .cal_busy, .closed_loop_en, .analog_sel, .irq);
   ecr_enc_model i_ecr_enc_model (.clock, .slow, .flt_n, .motion,
      .cal_axis, .pins);

   initial clock = 1'b0;
   always #2.5 clock = ~clock;

   // -------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------
   task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : cmp

   // One APB transfer; request held until ready is seen
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd

   // One calibration run with its expected speeds and load value
   task automatic cal(input logic [1:0] m, input logic lim,
                      input logic ext, input logic [1:0] ax);
      logic [31:0] ofs;
      logic [31:0] base;
      ofs  = $random(seed);
      base = ext ? vc : vn;
      // Analog select lets mode 2 reach the phase match
      apb(1'b1, {4'h1, ax, 2'b00}, {27'h0, lim, 1'b0, m, 1'b0});
      apb(1'b1, {4'h2, ax, 2'b00}, ofs);
      if (lim) vel_q.push_back(base);
      if (m != 2'h0 || !lim) begin
         vel_q.push_back(lim ? vs : (base < vx ? base : vx));
      end
      ld_q.push_back(m == 2'h1 ? ofs : 32'h0);
      apb(1'b1, 8'h40, {28'h0, ext, ax, 1'b1});
      // Second start while busy must be ignored
      apb(1'b1, 8'h40, {28'h0, ext, ~ax, 1'b1});
      for (int i = 0; i < 400 && cal_busy !== 1'b0; i++) @(posedge clock);
      rd(8'h48, 33'h0_0000_0001);
      cmp({31'h0, m[0]}, {31'h0, irq}); // Mask follows m[0]
      apb(1'b1, 8'h48, 32'h1);
      // Clear lands at the access edge; look one edge later
      @(posedge clock);
      cmp(32'h0, {31'h0, irq});
   endtask : cal

   task automatic results;
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results

   // -------------------------------------------------------------
   // Result watcher: oldest note against each result
   // -------------------------------------------------------------
   always @(posedge clock) begin : watch
      logic [32:0] e;
      mv_q <= {motion.move, motion.dir};
      if (psel && penable && pready && !pwrite && rd_q.size() != 0) begin
         e = rd_q.pop_front();
         if (e[32]) cmp(32'h1, {31'h0, pslverr});
         else cmp(e[31:0], prdata);
      end
      // An unexpected load compares against its own inverse
      if (motion.load === 1'b1) begin
         e[31:0] = ld_q.size() ? ld_q.pop_front() : ~motion.pos;
         cmp(e[31:0], motion.pos);
      end
      if (motion.move === 1'b1 && {motion.move, motion.dir} !== mv_q) begin
         e[31:0] = vel_q.size() ? vel_q.pop_front() : ~motion.vel;
         cmp(e[31:0], motion.vel);
      end
   end

   // Watchdog well beyond the longest expected run
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      results();
   end

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, nrst, slow} = '0;
      flt_n = 4'hF;
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      rd(8'h00, 33'h0_1010_1010);
      rd(8'h44, 33'h0_0000_0F00);
      cmp(32'hF, {28'h0, analog_sel});
      w = $random(seed) & 32'h1717_1717;
      apb(1'b1, 8'h00, w);
      apb(1'b1, 8'h14, 32'h0000_000B);
      rd(8'h00, {1'b0, (w & ~32'h1F00) | 32'h0B00});
      rd(8'h00, {1'b0, (w & ~32'h1F00) | 32'h0B00});
      rd(8'h80, 33'h1_0000_0000);
      apb(1'b1, 8'h81, 32'hFFFF_FFFF);
      rd(8'h10, 33'h0_0000_0017 & {1'b0, w});
      // Fault enabled on axis 2 only; axis 1 low but ignored
      apb(1'b1, 8'h00, 32'h1018_1010);
      flt_n <= 4'b1001;
      repeat (8) @(posedge clock);
      rd(8'h44, 33'h0_0000_0B46);
      cmp(32'hB, {28'h0, closed_loop_en});
      rd(8'h48, 33'h0_0000_0008);
      flt_n <= 4'hF;
      repeat (8) @(posedge clock);
      apb(1'b1, 8'h44, 32'h0000_00F0);
      apb(1'b1, 8'h48, 32'h0000_001F);
      rd(8'h44, 33'h0_0000_0F00);
      {vs, vn, vc, vx} = {$random(seed), $random(seed),
                          $random(seed), $random(seed)};
      // Search, normal, extended and ceiling velocities
      apb(1'b1, 8'h30, vs);
      apb(1'b1, 8'h34, vn);
      apb(1'b1, 8'h38, vc);
      apb(1'b1, 8'h3C, vx);
      for (int i = 0; i < 5; i++) begin
         slow <= i[0];
         apb(1'b1, 8'h4C, {31'h0, i == 1 || i == 3 || i == 4});
         cal(i == 4 ? 2'h1 : 2'(i), i != 4, i[1], 2'(i));
      end
      cmp(32'h0, ld_q.size() + vel_q.size());
      results();
   end
endmodule : ecr_top_tb
